// File: dv/i2c_link_master.sv
// Bus master model that sends one address frame on the I2C lines
module i2c_link_master (
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines idle high through the pull-ups
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Start, eight bits, released ack bit, stop
  task automatic frame(input logic [7:0] b);
    // Step off the sampling edge so no line moves on an aclk edge
    #10;
    sda = 1'b0;
    #160;
    scl = 1'b0;
    for (int i = 7; i >= -1; i--) begin
      #80;
      sda = (i < 0) ? 1'b1 : b[i];
      #80;
      scl = 1'b1;
      #160;
      scl = 1'b0;
    end
    #80;
    sda = 1'b0;
    #80;
    scl = 1'b1;
    #160;
    sda = 1'b1;
    #160;
  endtask : frame
endmodule : i2c_link_master

// File: dv/i2c_second_addr_flags_bench.sv
// Self-checking bench for the transfer flag block
`include "i2c_flags_defs.svh"
module i2c_second_addr_flags_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import i2c_flags_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic tde = 1'b0;
  logic rdf = 1'b0;
  logic oirq = 1'b0;
  mode_s mode = '0;
  logic awready, wready, bvalid, arready, rvalid, scl_in, sda_in, ctr, amx, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [6:0] sa;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int tno = 0;
  int m = 0;
  int arm = 0;
  bit fmt = 1'b0;
  // ==========================================================
  // Clock, partner and design
  always #20 aclk = ~aclk;
  i2c_link_master link (.scl(scl_in), .sda(sda_in));
  i2c_second_addr_flags dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .scl_in(scl_in), .sda_in(sda_in),
    .mode(mode), .tx_data_empty_flag(tde), .rx_data_full_flag(rdf), .other_irq_event(oirq),
    .continuous_transfer_req_flag(ctr), .second_addr_match_flag(amx), .iface_irq_flag(irq));
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic fin();
    tno++;
    $display("test %0d done", tno);
  endtask : fin
  // Watchdog on hung handshakes
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      complete_run();
    end
  end
  // ==========================================================
  // Bus tasks with the flag model
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int c;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
    if (a == `I2CF_OFS_STAT) begin
      c = arm & ~v & 32'h31;
      if (c[0]) c |= 32'h20;
      m &= ~c;
      arm = 0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
    if (a == `I2CF_OFS_STAT) arm = m;
  endtask : rd
  task automatic st();
    rd(`I2CF_OFS_STAT);
    chk(d, m);
    chk({26'h0, ctr, amx, 3'h0, irq}, m);
  endtask : st
  // Empty or full flag rise, request expected per mode and match
  task automatic ev(input bit rx);
    if (rx) rdf <= 1'b1;
    else tde <= 1'b1;
    @(posedge aclk);
    rdf <= 1'b0;
    tde <= 1'b0;
    repeat (2) @(posedge aclk);
    if (!mode.slave || m[4]) m |= 32'h21;
  endtask : ev
  // Start plus first byte, match expected per address and format
  task automatic fr(input logic [6:0] a);
    link.frame({a, 1'b1});
    repeat (8) @(posedge aclk);
    m &= ~32'h10;
    if (mode.slave && !mode.master && !fmt && a == sa) m |= 32'h10;
  endtask : fr
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(53904));
    sa = 7'($urandom);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    st();
    rd(`I2CF_OFS_ADDR);
    chk(d, 32'h0);
    fin();
    mode <= 2'b01;
    wr(`I2CF_OFS_ADDR, {24'h0, sa, 1'b0});
    rd(`I2CF_OFS_ADDR);
    chk(d, {24'h0, sa, 1'b0});
    fr(sa);
    wr(`I2CF_OFS_STAT, 32'h0);
    st();
    fin();
    ev(1'b0);
    st();
    wr(`I2CF_OFS_STAT, 32'h30);
    st();
    fin();
    fr(sa ^ 7'h01);
    st();
    ev(1'b1);
    st();
    fin();
    mode <= 2'b00;
    ev(1'b1);
    st();
    wr(`I2CF_OFS_STAT, 32'h0);
    st();
    fin();
    mode <= 2'b01;
    fmt = 1'b1;
    wr(`I2CF_OFS_ADDR, {24'h0, sa, 1'b1});
    fr(sa);
    st();
    fmt = 1'b0;
    wr(`I2CF_OFS_ADDR, {24'h0, sa, 1'b0});
    fr(sa);
    st();
    mode <= 2'b10;
    repeat (2) @(posedge aclk);
    m &= ~32'h10;
    st();
    oirq <= 1'b1;
    @(posedge aclk);
    oirq <= 1'b0;
    @(posedge aclk);
    m |= 32'h1;
    st();
    fin();
    rd(8'h08);
    chk({30'h0, r}, {30'h0, `I2CF_RESP_SLVERR});
    chk(d, 32'h0);
    wr(8'h08, 32'hff);
    chk({30'h0, r}, {30'h0, `I2CF_RESP_SLVERR});
    st();
    fin();
    complete_run();
  end
endmodule : i2c_second_addr_flags_bench

// File: dv/i2c_second_addr_flags_properties.sv
// Checker for the transfer flag block
module i2c_second_addr_flags_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic scl_in,
  input wire logic sda_in,
  input i2c_flags_pkg::mode_s mode,
  input wire logic tx_data_empty_flag,
  input wire logic rx_data_full_flag,
  input wire logic other_irq_event,
  input wire logic continuous_transfer_req_flag,
  input wire logic second_addr_match_flag,
  input wire logic iface_irq_flag
);
  import i2c_flags_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Events
  sequence s_ev;
    $rose(tx_data_empty_flag) || $rose(rx_data_full_flag);
  endsequence
  sequence s_start;
    scl_in && $fell(sda_in) ##1 (scl_in && !sda_in) [*3];
  endsequence
  // ==========================================================
  // Flag properties
  property p_free;
    s_ev ##0 !mode.slave |=> continuous_transfer_req_flag;
  endproperty
  a_free: assert property (p_free) else $error("request missed outside slave mode");
  property p_slave;
    s_ev ##0 (mode.slave && second_addr_match_flag) |=> continuous_transfer_req_flag;
  endproperty
  a_slave: assert property (p_slave) else $error("request missed in slave mode");
  property p_gate;
    s_ev ##0 (mode.slave && !second_addr_match_flag && !continuous_transfer_req_flag) |=>
      !continuous_transfer_req_flag;
  endproperty
  a_gate: assert property (p_gate) else $error("request raised without match");
  property p_cause;
    !continuous_transfer_req_flag && !($rose(tx_data_empty_flag) || $rose(rx_data_full_flag)) |=>
      !continuous_transfer_req_flag;
  endproperty
  a_cause: assert property (p_cause) else $error("request raised without event");
  property p_irq;
    $rose(continuous_transfer_req_flag) |-> iface_irq_flag;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt flag not raised with request");
  property p_ext;
    other_irq_event |=> iface_irq_flag;
  endproperty
  a_ext: assert property (p_ext) else $error("interrupt event lost");
  property p_master;
    $rose(mode.master) |=> !second_addr_match_flag;
  endproperty
  a_master: assert property (p_master) else $error("match kept in master mode");
  property p_mode;
    $rose(second_addr_match_flag) |-> $past(mode.slave && !mode.master);
  endproperty
  a_mode: assert property (p_mode) else $error("match set outside slave mode");
  property p_start;
    s_start |-> ##4 !second_addr_match_flag;
  endproperty
  a_start: assert property (p_start) else $error("match kept after start");
  property p_rst;
    $rose(aresetn) |-> !continuous_transfer_req_flag && !second_addr_match_flag && !iface_irq_flag;
  endproperty
  a_rst: assert property (p_rst) else $error("flags not clear after reset");
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule : i2c_second_addr_flags_properties

bind i2c_second_addr_flags i2c_second_addr_flags_properties chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .bresp(bresp),
  .bvalid(bvalid),
  .bready(bready),
  .rdata(rdata),
  .rvalid(rvalid),
  .rready(rready),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .mode(mode),
  .tx_data_empty_flag(tx_data_empty_flag),
  .rx_data_full_flag(rx_data_full_flag),
  .other_irq_event(other_irq_event),
  .continuous_transfer_req_flag(continuous_transfer_req_flag),
  .second_addr_match_flag(second_addr_match_flag),
  .iface_irq_flag(iface_irq_flag)
);

// File: rtl/i2c_first_frame.sv
// Start detection and capture of the first byte after a start condition
module i2c_first_frame (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl,
  input wire logic sda,
  output i2c_flags_pkg::frame_s frame
);
  import i2c_flags_pkg::*;

  logic scl_q;
  logic sda_q;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  frame_state_e state_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;

  // ==========================================================
  // Edge history of the synchronised lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // Start and stop are data edges while the clock line is high
  assign start_det = scl & scl_q & sda_q & !sda;
  assign stop_det = scl & scl_q & !sda_q & sda;
  assign scl_rise = scl & !scl_q;

  // ==========================================================
  // Shift in eight bits, MSB first, then wait for the next start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= FR_IDLE;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
    end else if (start_det) begin
      state_q <= FR_SHIFT;
      bit_cnt_q <= 3'h0;
    end else if (stop_det) begin
      state_q <= FR_IDLE;
    end else begin
      case (state_q)
        FR_SHIFT: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda};
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              state_q <= FR_DONE;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Pulse in the cycle the eighth bit is taken
  assign frame.start = start_det;
  assign frame.valid = (state_q == FR_SHIFT) && scl_rise && (bit_cnt_q == 3'h7) && !start_det && !stop_det;
  assign frame.data = {shift_q[6:0], sda};

endmodule : i2c_first_frame

// File: rtl/i2c_flags_defs.svh
// Register offsets, field positions and reset values of the transfer flag block
`ifndef I2C_FLAGS_DEFS_SVH
`define I2C_FLAGS_DEFS_SVH

// ==========================================================
// Register byte offsets
`define I2CF_OFS_ADDR 8'h00
`define I2CF_OFS_STAT 8'h04

// ==========================================================
// Second slave address register fields
`define I2CF_ADDR_TOP 7
`define I2CF_ADDR_BOT 1
`define I2CF_FMT_BIT 0
`define I2CF_ADDR_RST 8'h00

// ==========================================================
// Status register fields
`define I2CF_CTR_BIT 5
`define I2CF_AMX_BIT 4
`define I2CF_IRQ_BIT 0
`define I2CF_FLAG_RST 1'b0

// ==========================================================
// Bus answers and synchroniser depth
`define I2CF_RESP_OKAY 2'b00
`define I2CF_RESP_SLVERR 2'b10
`define I2CF_SYNC_STAGES 2

`endif

// File: rtl/i2c_flags_pkg.sv
// Types shared by the transfer flag block
package i2c_flags_pkg;

  // Operating mode levels from the interface core
  typedef struct packed {
    logic master;
    logic slave;
  } mode_s;

  // First frame after a start condition
  typedef struct packed {
    logic start;
    logic valid;
    logic [7:0] data;
  } frame_s;

  // Frame capture states, Gray coded
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_SHIFT = 2'b01,
    FR_DONE = 2'b11
  } frame_state_e;

endpackage : i2c_flags_pkg

// File: rtl/i2c_pin_sync.sv
// Two-stage synchroniser for asynchronous bus pins
module i2c_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] pin_sync
);

  // ==========================================================
  // Per-bit flip-flop pair
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic stable_q;
      // First stage feeds only the second
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_q <= 1'b1;
          stable_q <= 1'b1;
        end else begin
          meta_q <= pin[i];
          stable_q <= meta_q;
        end
      end
      assign pin_sync[i] = stable_q;
    end
  endgenerate

endmodule : i2c_pin_sync

// File: rtl/i2c_second_addr_flags.sv
// Continuous-transfer and second-address flags with an AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`include "i2c_flags_defs.svh"

// Operation
// - Slave: empty/full rise with match raises request
// - Not slave: empty/full rise raises request
// - Request 1 means continuous transfer state
// - First frame matching second address sets match
// - Match set only when format select 0
// - Clear by reading 1 then writing 0
// - Start condition clears match flag
// - Entering master mode clears match flag
// - Request raise also raises interface interrupt
// - Request clears by read/write or interrupt clear
module i2c_second_addr_flags (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Bus pins, sampled levels
  input wire logic scl_in,
  input wire logic sda_in,
  // Interface core status
  input i2c_flags_pkg::mode_s mode,
  input wire logic tx_data_empty_flag,
  input wire logic rx_data_full_flag,
  input wire logic other_irq_event,
  // Flag outputs
  output logic continuous_transfer_req_flag,
  output logic second_addr_match_flag,
  output logic iface_irq_flag
);
  import i2c_flags_pkg::*;

  // ==========================================================
  // Declarations
  logic [1:0] pins_sync;
  frame_s frame;
  logic aw_full_q;
  logic aw_full_d;
  logic [7:0] awaddr_q;
  logic w_full_q;
  logic w_full_d;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic bvalid_d;
  logic ar_fire;
  logic rvalid_d;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic stat_wr;
  logic stat_rd;
  logic [7:0] second_slave_addr_reg;
  logic ctr_q;
  logic amx_q;
  logic irq_q;
  logic arm_ctr_q;
  logic arm_amx_q;
  logic arm_irq_q;
  logic tde_q;
  logic rdf_q;
  logic master_q;
  logic data_event;
  logic ctr_set;
  logic ctr_clr;
  logic amx_set;
  logic amx_clr;
  logic irq_set;
  logic irq_clr;
  logic addr_match;

  // ==========================================================
  // Pin synchronisation and first-frame capture
  i2c_pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({scl_in, sda_in}),
    .pin_sync(pins_sync)
  );

  i2c_first_frame u_frame (
    .aclk(aclk),
    .aresetn(aresetn),
    .scl(pins_sync[1]),
    .sda(pins_sync[0]),
    .frame(frame)
  );

  // ==========================================================
  // Write channel: address and data held independently
  assign wr_fire = aw_full_q && w_full_q && !bvalid;
  assign aw_full_d = (aw_full_q && !wr_fire) || (awvalid && awready);
  assign w_full_d = (w_full_q && !wr_fire) || (wvalid && wready);
  assign bvalid_d = wr_fire || (bvalid && !bready);

  // Holding registers for address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready <= !aw_full_d;
      wready <= !w_full_d;
      if (awvalid && awready) begin
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
    end
  end

  // Write decode, word aligned
  always_comb begin
    wr_hit = 1'b0;
    stat_wr = 1'b0;
    if (awaddr_q == `I2CF_OFS_ADDR) begin
      wr_hit = 1'b1;
    end else if (awaddr_q == `I2CF_OFS_STAT) begin
      wr_hit = 1'b1;
      stat_wr = wr_fire && wstrb_q[0];
    end
  end

  // Write response, error for unmapped offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `I2CF_RESP_OKAY;
    end else begin
      bvalid <= bvalid_d;
      if (wr_fire) begin
        bresp <= wr_hit ? `I2CF_RESP_OKAY : `I2CF_RESP_SLVERR;
      end
    end
  end

  // Second slave address and format select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      second_slave_addr_reg <= `I2CF_ADDR_RST;
    end else if (wr_fire && wstrb_q[0] && (awaddr_q == `I2CF_OFS_ADDR)) begin
      second_slave_addr_reg <= wdata_q[7:0];
    end
  end

  // ==========================================================
  // Read channel: one read under way at a time
  assign ar_fire = arvalid && arready;
  assign rvalid_d = ar_fire || (rvalid && !rready);

  // Read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b0;
    stat_rd = 1'b0;
    if (araddr == `I2CF_OFS_ADDR) begin
      rd_hit = 1'b1;
      rd_word[7:0] = second_slave_addr_reg;
    end else if (araddr == `I2CF_OFS_STAT) begin
      rd_hit = 1'b1;
      stat_rd = ar_fire;
      rd_word[`I2CF_CTR_BIT] = ctr_q;
      rd_word[`I2CF_AMX_BIT] = amx_q;
      rd_word[`I2CF_IRQ_BIT] = irq_q;
    end
  end

  // Read data register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `I2CF_RESP_OKAY;
    end else begin
      arready <= !rvalid_d;
      rvalid <= rvalid_d;
      if (ar_fire) begin
        rdata <= rd_word;
        rresp <= rd_hit ? `I2CF_RESP_OKAY : `I2CF_RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // Read-then-write clear arming: a read that returns 1 arms the bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_ctr_q <= 1'b0;
      arm_amx_q <= 1'b0;
      arm_irq_q <= 1'b0;
    end else if (stat_rd) begin
      arm_ctr_q <= ctr_q;
      arm_amx_q <= amx_q;
      arm_irq_q <= irq_q;
    end else if (stat_wr) begin
      arm_ctr_q <= 1'b0;
      arm_amx_q <= 1'b0;
      arm_irq_q <= 1'b0;
    end
  end

  // ==========================================================
  // Event sources from the interface core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tde_q <= 1'b0;
      rdf_q <= 1'b0;
      master_q <= 1'b0;
    end else begin
      tde_q <= tx_data_empty_flag;
      rdf_q <= rx_data_full_flag;
      master_q <= mode.master;
    end
  end

  // Empty or full flag becoming 1
  assign data_event = (tx_data_empty_flag && !tde_q) || (rx_data_full_flag && !rdf_q);

  // ==========================================================
  // Continuous-transfer request flag
  assign ctr_set = data_event && (mode.slave ? amx_q : 1'b1);
  assign ctr_clr = (stat_wr && !wdata_q[`I2CF_CTR_BIT] && arm_ctr_q) || irq_clr;

  // Set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctr_q <= `I2CF_FLAG_RST;
    end else if (ctr_set) begin
      ctr_q <= 1'b1;
    end else if (ctr_clr) begin
      ctr_q <= 1'b0;
    end
  end

  // ==========================================================
  // Interface interrupt flag
  assign irq_set = ctr_set || other_irq_event;
  assign irq_clr = stat_wr && !wdata_q[`I2CF_IRQ_BIT] && arm_irq_q;

  // Raised in the same cycle as the request flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= `I2CF_FLAG_RST;
    end else if (irq_set) begin
      irq_q <= 1'b1;
    end else if (irq_clr) begin
      irq_q <= 1'b0;
    end
  end

  // ==========================================================
  // Second-address match flag
  assign addr_match = frame.data[7:1] == second_slave_addr_reg[`I2CF_ADDR_TOP:`I2CF_ADDR_BOT];
  assign amx_set = frame.valid && mode.slave && !mode.master && addr_match
    && !second_slave_addr_reg[`I2CF_FMT_BIT];
  assign amx_clr = frame.start
    || (mode.master && !master_q)
    || (stat_wr && !wdata_q[`I2CF_AMX_BIT] && arm_amx_q);

  // Set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      amx_q <= `I2CF_FLAG_RST;
    end else if (amx_set) begin
      amx_q <= 1'b1;
    end else if (amx_clr) begin
      amx_q <= 1'b0;
    end
  end

  // ==========================================================
  // Flag outputs straight from flops
  assign continuous_transfer_req_flag = ctr_q;
  assign second_addr_match_flag = amx_q;
  assign iface_irq_flag = irq_q;

endmodule : i2c_second_addr_flags
